/* File: hdl/fail_safe_clock_monitor_regs.svh */
// Purpose: Register offsets, fields, reset values and timing counts
// Assumes: Plain register port, 8-bit data in the low bits
// Notes: Included by the clock monitor top
// Behaviour
// R1: Monitor enabled only by configuration enable bit
// R2: Sample clock is low-frequency oscillator over 64
// R3: Falling external edge sets, sample rise clears latch
// R4: Failure when half sample period has no low
// R5: Failure switches to internal source, sets flag
// R6: Interrupt only while flag and enable set
// R7: Stay internal until firmware switches back
// R8: Fallback frequency follows frequency select field
// R9: Reset, sleep or select change clears condition
// R10: Select change restarts start-up timer
// R11: Condition cleared after successful external switch
// R12: Firmware clears flag before switching back
// R13: Persisting failure sets flag again
// R14: Detection waits for timer; none for EC/RC
// R15: Monitor enable also enables two-speed start-up
// R16: Config PLL forces PLL; else software bit
// R17: Frequency select reset 0111, full code map
// R18: Select 1x internal, 01 timer1, 00 config
// R19: Timer status 1 on configured external source, 0 otherwise
// R20: Timer1 ready reads 1 while disabled
// R21: Read-only ready, locked and stable bits
// R22: Six-bit two's complement trim field
// R23: Clock select cleared on every reset
// R24: Timer counts 1024 cycles in crystal modes
// R25: Latch and divider reset on device reset
`ifndef FAIL_SAFE_CLOCK_MONITOR_REGS_SVH
`define FAIL_SAFE_CLOCK_MONITOR_REGS_SVH
`define FAIL_SAFE_CLOCK_MONITOR_OFS_CONTROL 4'h0
`define FAIL_SAFE_CLOCK_MONITOR_OFS_STATUS 4'h1
`define FAIL_SAFE_CLOCK_MONITOR_OFS_TUNING 4'h2
`define FAIL_SAFE_CLOCK_MONITOR_OFS_IRQ 4'h3
`define FAIL_SAFE_CLOCK_MONITOR_PLL_BIT 7
`define FAIL_SAFE_CLOCK_MONITOR_FREQ_MSB 6
`define FAIL_SAFE_CLOCK_MONITOR_FREQ_LSB 3
`define FAIL_SAFE_CLOCK_MONITOR_FREQ_RESET 4'h7
`define FAIL_SAFE_CLOCK_MONITOR_SAMPLE_DIV 64
`define FAIL_SAFE_CLOCK_MONITOR_OST_CYCLES 1024
`endif

/* File: hdl/fail_safe_clock_monitor_pkg.sv */
// Purpose: Types for the clock monitor
// Assumes: Nothing beyond the register header
// Notes: Source and mode encodings
`default_nettype none
package fail_safe_clock_monitor_pkg;
   // Configured oscillator mode
   typedef enum logic [2:0]
   {
      FAIL_SAFE_CLOCK_MONITOR_MODE_LP = 3'h0,
      FAIL_SAFE_CLOCK_MONITOR_MODE_XT = 3'h1,
      FAIL_SAFE_CLOCK_MONITOR_MODE_HS = 3'h2,
      FAIL_SAFE_CLOCK_MONITOR_MODE_EC = 3'h3,
      FAIL_SAFE_CLOCK_MONITOR_MODE_INT = 3'h4,
      FAIL_SAFE_CLOCK_MONITOR_MODE_RC = 3'h5
   } fail_safe_clock_monitor_mode_t;
   // One-hot clock source states
   typedef enum logic [2:0]
   {
      FAIL_SAFE_CLOCK_MONITOR_ST_START = 3'b001,
      FAIL_SAFE_CLOCK_MONITOR_ST_EXT = 3'b010,
      FAIL_SAFE_CLOCK_MONITOR_ST_FAIL = 3'b100
   } fail_safe_clock_monitor_state_t;
endpackage
`default_nettype wire

/* File: hdl/fail_safe_clock_monitor_monitor.sv */
// Purpose: Clock monitor, oscillator control, status and tuning regs
// Assumes: Oscillator edges and ready levels arrive asynchronously
// Notes: External and low-freq clocks are sampled on the system clock
`default_nettype none
`include "fail_safe_clock_monitor_regs.svh"
module fail_safe_clock_monitor_monitor
   import fail_safe_clock_monitor_pkg::*;
#(
   parameter int OST_COUNT = `FAIL_SAFE_CLOCK_MONITOR_OST_CYCLES,
   parameter int SAMPLE_DIV = `FAIL_SAFE_CLOCK_MONITOR_SAMPLE_DIV
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clockEnable,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regReadData,
   input wire logic failMonitorEnableCfg,
   input wire logic twoSpeedStartCfg,
   input wire logic configPllEnable,
   input wire logic [2:0] oscModeCfg,
   input wire logic sleepExec,
   input wire logic extClockPin,
   input wire logic lowFreqOscPin,
   input wire logic timer1OscEnable,
   input wire logic timer1OscReadyPin,
   input wire logic pllReadyPin,
   input wire logic hfReadyPin,
   input wire logic hfLockedPin,
   input wire logic hfStablePin,
   input wire logic mfReadyPin,
   input wire logic lfReadyPin,
   output logic useInternalOsc,
   output logic [3:0] internalFreqSelect,
   output logic pllOn,
   output logic [5:0] frequencyTrim,
   output logic oscFailIrq
);
   localparam int DIVW = $clog2(SAMPLE_DIV);
   localparam int OSTW = $clog2(OST_COUNT + 1);
   localparam int HALF_DIV = SAMPLE_DIV / 2;

   // Two-flop synchronisers for every asynchronous level
   // Only the second stage is read by any logic
   logic [8:0] syncA_q;
   logic [8:0] syncB_q;
   wire logic [8:0] rawIn = {extClockPin, lowFreqOscPin,
      timer1OscReadyPin, pllReadyPin, hfReadyPin, hfLockedPin,
      hfStablePin, mfReadyPin, lfReadyPin};
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         syncA_q <= 9'h000;
         syncB_q <= 9'h000;
      end
      else if (clockEnable)
      begin
         syncA_q <= rawIn;
         syncB_q <= syncA_q;
      end
   end
   wire logic extS = syncB_q[8];
   wire logic lfS = syncB_q[7];

   // Edge history of synchronised clocks
   // Cleared history gives at most a rising edge after reset
   logic extPrev_q;
   logic lfPrev_q;
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         extPrev_q <= 1'b0;
         lfPrev_q <= 1'b0;
      end
      else if (clockEnable)
      begin
         extPrev_q <= extS;
         lfPrev_q <= lfS;
      end
   end
   wire logic extFall = extPrev_q & ~extS;
   wire logic lfRise = lfS & ~lfPrev_q;

   // Sample clock: low-frequency edges divided down
   // The count wrap is its rising edge, the half count its
   // falling edge; only the half period between them is watched
   logic [DIVW-1:0] divCnt_q; // Low-frequency edge count
   wire logic sampleRise = lfRise && (divCnt_q == DIVW'(SAMPLE_DIV - 1));
   wire logic sampleFall = lfRise && (divCnt_q == DIVW'(HALF_DIV - 1));
   always_ff @(posedge clock)
   begin
      if (rst) // see R25
      begin
         divCnt_q <= '0;
      end
      else if (clockEnable && lfRise) // see R2
      begin
         divCnt_q <= divCnt_q + DIVW'(1);
      end
   end

   // Address decode shared by the write and read paths
   function automatic logic regHit(input logic [3:0] addr,
      input logic [3:0] ofs);
      regHit = (addr == ofs);
   endfunction

   // Registers written by software
   logic pllBit_q; // Software PLL request
   logic [3:0] freqSel_q; // Internal frequency select
   logic [1:0] clkSel_q; // System clock select
   logic [5:0] trim_q; // Frequency trim, two's complement
   logic failIrqEn_q; // Fail interrupt enable
   // Write strobes, one per writable register
   wire logic wrCtl = regWrite && regHit(regAddr, `FAIL_SAFE_CLOCK_MONITOR_OFS_CONTROL);
   wire logic wrTune = regWrite && regHit(regAddr, `FAIL_SAFE_CLOCK_MONITOR_OFS_TUNING);
   wire logic wrIrq = regWrite && regHit(regAddr, `FAIL_SAFE_CLOCK_MONITOR_OFS_IRQ);
   // Any write that alters the select bits restarts start-up
   wire logic [1:0] newSel = regWriteData[1:0];
   wire logic selChange = wrCtl && (newSel != clkSel_q);
   // Sleep or select change only counts on enabled cycles,
   // so a frozen block keeps all of its state
   wire logic condClear = clockEnable && (sleepExec || selChange);
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pllBit_q <= 1'b0;
         freqSel_q <= `FAIL_SAFE_CLOCK_MONITOR_FREQ_RESET; // see R17
         clkSel_q <= 2'h0; // see R23
         trim_q <= 6'h00;
         failIrqEn_q <= 1'b0;
      end
      else if (clockEnable)
      begin
         if (wrCtl)
         begin
            pllBit_q <= regWriteData[`FAIL_SAFE_CLOCK_MONITOR_PLL_BIT];
            freqSel_q <= regWriteData[`FAIL_SAFE_CLOCK_MONITOR_FREQ_MSB:`FAIL_SAFE_CLOCK_MONITOR_FREQ_LSB];
            clkSel_q <= newSel; // see R18
         end
         if (wrTune)
         begin
            trim_q <= regWriteData[5:0]; // see R22
         end
         if (wrIrq)
         begin
            failIrqEn_q <= regWriteData[1];
         end
      end
   end

   // Mode decode
   // Timer1 and crystal modes need the start-up timer
   wire logic crystalMode = (oscModeCfg == FAIL_SAFE_CLOCK_MONITOR_MODE_LP) ||
      (oscModeCfg == FAIL_SAFE_CLOCK_MONITOR_MODE_XT) || (oscModeCfg == FAIL_SAFE_CLOCK_MONITOR_MODE_HS);
   wire logic extSelected = (clkSel_q == 2'b01) ||
      ((clkSel_q == 2'b00) && (oscModeCfg != FAIL_SAFE_CLOCK_MONITOR_MODE_INT));
   wire logic timerNeeded = crystalMode || (clkSel_q == 2'b01);
   wire logic twoSpeed = twoSpeedStartCfg || failMonitorEnableCfg; // see R15

   // Start-up timer counts external falling edges
   // No timer in external-clock, RC or internal modes: done at once,
   // so in external-clock and RC modes monitoring starts right after reset or wake-up
   logic [OSTW-1:0] ost_q;
   wire logic ostDone = !timerNeeded || (ost_q == OSTW'(OST_COUNT));
   fail_safe_clock_monitor_state_t state_q;
   fail_safe_clock_monitor_state_t state_d;
   always_ff @(posedge clock)
   begin
      if (rst || condClear) // see R10
      begin
         ost_q <= '0;
      end
      else if (clockEnable && extFall && !ostDone) // see R24
      begin
         ost_q <= ost_q + OSTW'(1);
      end
   end

   // Detector latch and half-period watch
   // A falling external edge sets the latch, a sample rise clears it;
   // still clear at the sample fall means a whole half period passed
   logic latch_q; // Detector latch
   // Armed after the first sample rise, so no partial half period
   // can report a failure
   logic armed_q;
   wire logic monActive = failMonitorEnableCfg && extSelected
      && ostDone; // see R1 R14
   wire logic failDetect = monActive && armed_q && sampleFall
      && !latch_q; // see R4
   always_ff @(posedge clock)
   begin
      if (rst) // see R25
      begin
         latch_q <= 1'b0;
         armed_q <= 1'b0;
      end
      else if (clockEnable)
      begin
         if (extFall) // see R3
         begin
            latch_q <= 1'b1;
         end
         else if (sampleRise)
         begin
            latch_q <= 1'b0;
         end
         if (sampleRise)
         begin
            armed_q <= 1'b1;
         end
      end
   end

   // Clock source state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         FAIL_SAFE_CLOCK_MONITOR_ST_START:
         begin
            // Move to external once the timer has run out
            if (extSelected && ostDone) // see R11
            begin
               state_d = FAIL_SAFE_CLOCK_MONITOR_ST_EXT;
            end
         end
         FAIL_SAFE_CLOCK_MONITOR_ST_EXT:
         begin
            if (!extSelected)
            begin
               state_d = FAIL_SAFE_CLOCK_MONITOR_ST_START;
            end
            else if (failDetect) // see R5
            begin
               state_d = FAIL_SAFE_CLOCK_MONITOR_ST_FAIL;
            end
         end
         FAIL_SAFE_CLOCK_MONITOR_ST_FAIL:
         begin
            // Only reset, sleep or a select change leaves here
            state_d = FAIL_SAFE_CLOCK_MONITOR_ST_FAIL; // see R7
         end
         default:
         begin
            state_d = FAIL_SAFE_CLOCK_MONITOR_ST_START;
         end
      endcase
   end
   always_ff @(posedge clock)
   begin
      if (rst || condClear) // see R9
      begin
         state_q <= FAIL_SAFE_CLOCK_MONITOR_ST_START;
      end
      else if (clockEnable)
      begin
         state_q <= state_d;
      end
   end

   // Fail flag: set wins over clear
   // A failure in the same cycle as a clear keeps the flag set
   logic failFlag_q;
   wire logic flagClear = wrIrq && !regWriteData[0];
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         failFlag_q <= 1'b0;
      end
      else if (clockEnable)
      begin
         if (failDetect) // see R5 R13
         begin
            failFlag_q <= 1'b1;
         end
         else if (flagClear) // see R12
         begin
            failFlag_q <= 1'b0;
         end
      end
   end

   // Status assembly
   // Start-up status is high only on the configured source
   wire logic onExternal = (state_q == FAIL_SAFE_CLOCK_MONITOR_ST_EXT);
   wire logic t1Ready = timer1OscEnable ? syncB_q[6] : 1'b1; // see R20
   wire logic [7:0] statusWord = {t1Ready, syncB_q[5],
      onExternal && (clkSel_q == 2'b00), syncB_q[4], syncB_q[3],
      syncB_q[1], syncB_q[0], syncB_q[2]}; // see R19 R21
   // Read selection; unmapped offsets and reserved bits read zero
   wire logic [7:0] rdMux =
      regHit(regAddr, `FAIL_SAFE_CLOCK_MONITOR_OFS_CONTROL) ?
         {pllBit_q, freqSel_q, 1'b0, clkSel_q} :
      regHit(regAddr, `FAIL_SAFE_CLOCK_MONITOR_OFS_STATUS) ? statusWord :
      regHit(regAddr, `FAIL_SAFE_CLOCK_MONITOR_OFS_TUNING) ? {2'b00, trim_q} :
      regHit(regAddr, `FAIL_SAFE_CLOCK_MONITOR_OFS_IRQ) ?
         {6'h00, failIrqEn_q, failFlag_q} :
      8'h00;
   // Internal source after a failure, while starting with two-speed on, or when selected
   wire logic internalNow = (state_q == FAIL_SAFE_CLOCK_MONITOR_ST_FAIL) ||
      (!onExternal && (twoSpeed || !extSelected));

   // Registered outputs
   // Every output is a flop; read data is zero outside reads
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         regReadData <= 8'h00;
         useInternalOsc <= 1'b0;
         internalFreqSelect <= `FAIL_SAFE_CLOCK_MONITOR_FREQ_RESET;
         pllOn <= 1'b0;
         frequencyTrim <= 6'h00;
         oscFailIrq <= 1'b0;
      end
      else if (clockEnable)
      begin
         regReadData <= regRead ? rdMux : 8'h00;
         useInternalOsc <= internalNow; // see R5 R10
         internalFreqSelect <= freqSel_q; // see R8
         pllOn <= configPllEnable | pllBit_q; // see R16
         frequencyTrim <= trim_q;
         oscFailIrq <= failFlag_q & failIrqEn_q; // see R6
      end
   end

   // Checks
   chk_fail_sets_flag: assert property ( // see R5
      @(posedge clock) disable iff (rst)
      clockEnable && failDetect |=> failFlag_q)
      else $error("fail did not set flag");
   chk_irq_gating: assert property ( // see R6
      @(posedge clock) disable iff (rst)
      clockEnable |=> oscFailIrq == $past(failFlag_q & failIrqEn_q))
      else $error("irq not gated by enable");
   chk_fail_holds: assert property ( // see R7
      @(posedge clock) disable iff (rst)
      state_q == FAIL_SAFE_CLOCK_MONITOR_ST_FAIL && !condClear |=> state_q == FAIL_SAFE_CLOCK_MONITOR_ST_FAIL)
      else $error("fail state left early");
   chk_clear_cond: assert property ( // see R9
      @(posedge clock) disable iff (rst)
      condClear |=> state_q == FAIL_SAFE_CLOCK_MONITOR_ST_START)
      else $error("condition not cleared");
   chk_no_early: assert property ( // see R14
      @(posedge clock) disable iff (rst)
      !ostDone |-> !failDetect)
      else $error("detect before timer");
   chk_pll_force: assert property ( // see R16
      @(posedge clock) disable iff (rst)
      clockEnable && configPllEnable |=> pllOn)
      else $error("pll not forced");
   chk_t1_ready: assert property ( // see R20
      @(posedge clock) disable iff (rst)
      !timer1OscEnable |-> statusWord[7])
      else $error("timer1 ready low");
   chk_disabled_mon: assert property ( // see R1
      @(posedge clock) disable iff (rst)
      !failMonitorEnableCfg |-> !failDetect)
      else $error("detect while disabled");
   chk_ost_reset: assert property ( // see R10
      @(posedge clock) disable iff (rst)
      condClear |=> ost_q == '0)
      else $error("timer not restarted");
   chk_latch_set: assert property ( // see R3
      @(posedge clock) disable iff (rst)
      clockEnable && extFall |=> latch_q)
      else $error("latch not set by falling edge");
   chk_fail_internal: assert property ( // see R5
      @(posedge clock) disable iff (rst)
      clockEnable && state_q == FAIL_SAFE_CLOCK_MONITOR_ST_FAIL |=> useInternalOsc)
      else $error("no internal source after failure");
   chk_freq_follow: assert property ( // see R8
      @(posedge clock) disable iff (rst)
      clockEnable |=> internalFreqSelect == $past(freqSel_q))
      else $error("fallback frequency not followed");
   cov_failure: cover property (@(posedge clock) failDetect);
   cov_irq: cover property (@(posedge clock) oscFailIrq);
   cov_external: cover property (@(posedge clock) onExternal);
   cov_restart: cover property (@(posedge clock)
      condClear && state_q == FAIL_SAFE_CLOCK_MONITOR_ST_FAIL);
   cov_flag_clear: cover property (@(posedge clock) flagClear && failFlag_q);
endmodule
`default_nettype wire

/* File: verif/fail_safe_clock_monitor_osc_model.sv */
// Purpose: External oscillator and low-frequency oscillator stand-in
// Assumes: Runs off the bench system clock
// Notes: A stopped oscillator sticks high, so no falling edges arrive
`default_nettype none
module fail_safe_clock_monitor_osc_model
(
   input wire logic clock,
   input wire logic oscRun,
   output logic extClockPin,
   output logic lowFreqOscPin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Cycle counters for both oscillators
   logic [1:0] extCnt = 2'h0;
   logic [3:0] lfCnt = 4'h0;
   // Pin levels, one process each; a stopped oscillator rests high
   logic extLvl = 1'b1;
   logic lfLvl = 1'b0;
   assign extClockPin = extLvl;
   assign lowFreqOscPin = lfLvl;
   // External clock: period of four system cycles while running
   always @(posedge clock)
   begin
      extCnt <= extCnt + 2'h1;
      if (!oscRun)
         extLvl <= 1'b1;
      else if (extCnt[0])
         extLvl <= ~extLvl;
   end
   // Low-frequency clock: toggles every ten cycles, free running
   always @(posedge clock)
   begin
      lfCnt <= (lfCnt == 4'h9) ? 4'h0 : lfCnt + 4'h1;
      if (lfCnt == 4'h9)
         lfLvl <= ~lfLvl;
   end
endmodule
`default_nettype wire

/* File: verif/fail_safe_clock_monitor_tb.sv */
// Purpose: Self-checking bench for the clock monitor
// Assumes: Start-up count 8 and sample divide 4 for short runs
// Notes: Crystal mode throughout, monitor enabled until the last test;
// two-speed config low, so only the monitor enable forces it
`default_nettype none
module fail_safe_clock_monitor_tb;
   import fail_safe_clock_monitor_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWriteData = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regReadData;
   logic failEn = 1'b1;
   logic cfgPll = 1'b0;
   logic sleepExec = 1'b0;
   logic oscRun = 1'b1;
   logic t1En = 1'b0;
   logic ce = 1'b1;
   // Ready pins: t1, pll, hfR, hfL, mf, lf, hfS
   logic [6:0] rdy = 7'h00;
   logic extClk, lfClk, useInt, pllOn, irq;
   logic [3:0] freqSel;
   logic [5:0] trim;
   logic [7:0] rd;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   always #5 clock = ~clock;
   fail_safe_clock_monitor_osc_model osc (.clock(clock), .oscRun(oscRun),
      .extClockPin(extClk), .lowFreqOscPin(lfClk));
   fail_safe_clock_monitor_monitor #(.OST_COUNT(8), .SAMPLE_DIV(4)) uut (.clock(clock),
      .rst(rst), .clockEnable(ce), .regAddr(regAddr),
      .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
      .regReadData(regReadData), .failMonitorEnableCfg(failEn),
      .twoSpeedStartCfg(1'b0), .configPllEnable(cfgPll),
      .oscModeCfg(FAIL_SAFE_CLOCK_MONITOR_MODE_XT), .sleepExec(sleepExec),
      .extClockPin(extClk), .lowFreqOscPin(lfClk),
      .timer1OscEnable(t1En), .timer1OscReadyPin(rdy[6]),
      .pllReadyPin(rdy[5]), .hfReadyPin(rdy[4]), .hfLockedPin(rdy[3]),
      .hfStablePin(rdy[0]), .mfReadyPin(rdy[2]), .lfReadyPin(rdy[1]),
      .useInternalOsc(useInt), .internalFreqSelect(freqSel),
      .pllOn(pllOn), .frequencyTrim(trim), .oscFailIrq(irq));
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= a;
      regWriteData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
      #1;
   endtask
   task automatic rdreg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      d = regReadData;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic t_reset;
      rdreg(4'h0, rd); chk(rd, 8'h38);
      chk({4'h0, freqSel}, 8'h07);
      rdreg(4'h2, rd); chk(rd, 8'h00);
      rdreg(4'h3, rd); chk(rd, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_regs;
      wr(4'h0, 8'hFF); rdreg(4'h0, rd); chk(rd, 8'hFB);
      chk({3'h0, pllOn, freqSel}, 8'h1F);
      chk({7'h0, useInt}, 8'h01);
      wr(4'h0, 8'h78); idle(1); chk({7'h0, pllOn}, 8'h00);
      cfgPll <= 1'b1; idle(3); chk({7'h0, pllOn}, 8'h01);
      cfgPll <= 1'b0;
      wr(4'h0, 8'h38);
      wr(4'h2, 8'hFF); rdreg(4'h2, rd); chk(rd, 8'h3F);
      ce <= 1'b0; wr(4'h2, 8'h11); ce <= 1'b1;
      rdreg(4'h2, rd); chk(rd, 8'h3F);
      wr(4'h2, 8'h20); idle(1); chk({2'h0, trim}, 8'h20);
      wr(4'h9, 8'hAA); rdreg(4'h9, rd); chk(rd, 8'h00);
      $display("register test done");
   endtask
   task automatic t_status;
      rdy <= 7'b0101010; idle(100);
      rdreg(4'h1, rd); chk(rd, 8'hEA);
      t1En <= 1'b1; rdy <= 7'b0010101; idle(6);
      rdreg(4'h1, rd); chk(rd, 8'h35);
      $display("status test done");
   endtask
   task automatic t_fail;
      chk({7'h0, useInt}, 8'h00);
      oscRun <= 1'b0; idle(300);
      chk({7'h0, useInt}, 8'h01);
      chk({4'h0, freqSel}, 8'h07);
      rdreg(4'h3, rd); chk(rd, 8'h01);
      chk({7'h0, irq}, 8'h00);
      wr(4'h3, 8'h03); idle(2); chk({7'h0, irq}, 8'h01);
      idle(300); rdreg(4'h3, rd); chk(rd, 8'h03);
      chk({7'h0, useInt}, 8'h01);
      oscRun <= 1'b1; idle(20);
      wr(4'h3, 8'h02);
      @(posedge clock); sleepExec <= 1'b1;
      @(posedge clock); sleepExec <= 1'b0;
      idle(4); rdreg(4'h1, rd); chk(rd, 8'h15);
      chk({7'h0, useInt}, 8'h01);
      idle(200); chk({7'h0, useInt}, 8'h00);
      rdreg(4'h3, rd); chk(rd, 8'h02);
      $display("failure test done");
   endtask
   task automatic t_off;
      failEn <= 1'b0; oscRun <= 1'b0; idle(300);
      rdreg(4'h3, rd); chk(rd, 8'h02);
      chk({7'h0, irq}, 8'h00);
      $display("disabled test done");
   endtask
   task automatic close_out;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         close_out();
      end
   end
   initial
   begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_status();
      t_fail();
      t_off();
      close_out();
   end
endmodule
`default_nettype wire
